// [verilog/dosel_pkg.sv]
// Function
// R1: Mode change only when stopped, starts off.
// R2: Nonzero startup setting starts in network mode.
// R3: Network parameter writes accepted only in network mode.
// R4: Startup setting applies after next reset only.
// R5: Panel may write startup setting in any mode.
// R6: Setting 0/0: terminal start, no panel-network hop.
// R7: Select 1: panel mode start, held permanently.
// R8: Select 2: terminal/network switching only, panel refused.
// R9: Select 3 or 4: combined mode, switching refused.
// R10: Select 6: free switching even while running.
// R11: Select 7: lock off forces terminal mode.
// R12: Startup 1/2 starts network; switching as 0.
// R13: Startup 10/12, select 0: panel-network switching only.
// R14: Startup 10/12, select 2: network mode held.
// R15: Startup 10/12, select 6: panel-network while running.
// R16: Panel-network switching from panel or switch input.
// R17: Coast time not 9999 resumes after power dip.
// R18: Startup 1/10 clears active start on dip.
// R19: Startup 10/12 other selects behave like 0.
package dosel_pkg;

	// ----------------------------------------------------------------
	// Register map and field layout
	// ----------------------------------------------------------------
	localparam int          DATA_W         = 16;
	localparam int          ADDR_W         = 3;
	localparam logic [2:0]  REG_STARTUP    = 3'h0;
	localparam logic [2:0]  REG_MODESEL    = 3'h1;
	localparam logic [2:0]  REG_COAST      = 3'h2;
	localparam logic [2:0]  REG_MODE_REQ   = 3'h3;
	localparam logic [2:0]  REG_STATUS     = 3'h4;
	localparam int          ST_MODE_LSB    = 0;
	localparam int          ST_REFUSED_BIT = 2;
	localparam int          ST_NETEN_BIT   = 3;
	localparam int          ST_ACTIVE_LSB  = 8;

	// ----------------------------------------------------------------
	// Reset values and setting codes
	// ----------------------------------------------------------------
	localparam logic [7:0]  STARTUP_RST    = 8'h00;
	localparam logic [3:0]  MODESEL_RST    = 4'h0;
	localparam logic [15:0] COAST_NONE     = 16'h270f;
	localparam logic [15:0] COAST_RST      = 16'h270f;
	localparam logic [7:0]  SU_0           = 8'h00;
	localparam logic [7:0]  SU_1           = 8'h01;
	localparam logic [7:0]  SU_2           = 8'h02;
	localparam logic [7:0]  SU_10          = 8'h0a;
	localparam logic [7:0]  SU_12          = 8'h0c;
	localparam logic [3:0]  MS_0           = 4'h0;
	localparam logic [3:0]  MS_1           = 4'h1;
	localparam logic [3:0]  MS_2           = 4'h2;
	localparam logic [3:0]  MS_3           = 4'h3;
	localparam logic [3:0]  MS_4           = 4'h4;
	localparam logic [3:0]  MS_6           = 4'h6;
	localparam logic [3:0]  MS_7           = 4'h7;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_TERMINAL,
		MODE_PANEL,
		MODE_NETWORK,
		MODE_COMBINED
	} dosel_mode_e;

	typedef struct packed {
		logic [7:0]  startup_set;
		logic [7:0]  startup_act;
		logic [3:0]  modesel;
		logic [15:0] coast;
		dosel_mode_e mode;
		logic        refused;
		logic        net_en;
		logic        pu_prev;
		logic        init;
		logic [15:0] rdata;
		logic        net_ack;
		logic        net_nak;
		logic        resume;
		logic        start_clear;
	} dosel_state_s;

endpackage

// [verilog/dosel_start_decode.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Starting mode at power-on, reset and power recovery
// ----------------------------------------------------------------
module dosel_start_decode (
	input  wire logic [7:0]          startup_in,
	input  wire logic [3:0]          modesel_in,
	input  wire logic                lock_in,
	output dosel_pkg::dosel_mode_e   mode_out
);

	logic su_net;

	// Startup codes 1 and 2 honour the lock input under select 7; 10 and 12 do not.
	assign su_net = (startup_in == dosel_pkg::SU_1) || (startup_in == dosel_pkg::SU_2);

	// Select decides first, the startup code only picks terminal or network.
	always_comb begin
		if (modesel_in == dosel_pkg::MS_1) begin
			mode_out = dosel_pkg::MODE_PANEL; // see R7
		end else if (modesel_in == dosel_pkg::MS_3 || modesel_in == dosel_pkg::MS_4) begin
			mode_out = dosel_pkg::MODE_COMBINED; // see R9
		end else if (modesel_in == dosel_pkg::MS_7) begin
			mode_out = (su_net && lock_in) ? dosel_pkg::MODE_NETWORK : dosel_pkg::MODE_TERMINAL; // see R12 see R19
		end else if (startup_in != dosel_pkg::SU_0) begin
			mode_out = dosel_pkg::MODE_NETWORK; // see R2
		end else begin
			mode_out = dosel_pkg::MODE_TERMINAL; // see R6
		end
	end

endmodule

// [verilog/dosel_mode_ctrl.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Drive operation mode selector
// ----------------------------------------------------------------
module dosel_mode_ctrl (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic [2:0]  addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	input  wire logic        drive_reset_in,
	input  wire logic        power_restore_in,
	input  wire logic        running_in,
	input  wire logic        forward_start_input_in,
	input  wire logic        reverse_start_input_in,
	input  wire logic        mode_lock_input_in,
	input  wire logic        pu_net_switch_input_in,
	input  wire logic        panel_mode_req_in,
	input  wire logic [1:0]  panel_mode_tgt_in,
	input  wire logic        panel_startup_wr_in,
	input  wire logic [7:0]  panel_startup_data_in,
	input  wire logic        net_write_req_in,
	output logic [15:0]      rdata_out,
	output logic [1:0]       mode_out,
	output logic             net_write_en_out,
	output logic             net_write_ack_out,
	output logic             net_write_nak_out,
	output logic             refused_out,
	output logic             resume_out,
	output logic             start_clear_out
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic is_wide(input logic [7:0] su);
		return (su == dosel_pkg::SU_10) || (su == dosel_pkg::SU_12);
	endfunction

	// Decides whether a switch from cur to tgt may be carried out now.
	function automatic logic allow_switch(
		input logic [7:0]            su,
		input logic [3:0]            sel,
		input dosel_pkg::dosel_mode_e cur,
		input dosel_pkg::dosel_mode_e tgt,
		input logic                  by_panel,
		input logic                  stopped
	);
		logic ok;
		logic pn;
		pn = ((cur == dosel_pkg::MODE_PANEL) && (tgt == dosel_pkg::MODE_NETWORK)) ||
		     ((cur == dosel_pkg::MODE_NETWORK) && (tgt == dosel_pkg::MODE_PANEL));
		ok = 1'b0;
		if (tgt == cur || tgt == dosel_pkg::MODE_COMBINED || cur == dosel_pkg::MODE_COMBINED) begin
			ok = 1'b0; // see R9
		end else if (is_wide(su) && (sel == dosel_pkg::MS_0 || sel == dosel_pkg::MS_6)) begin
			ok = pn && by_panel; // see R13 see R15 see R16
		end else if (is_wide(su) && sel == dosel_pkg::MS_2) begin
			ok = 1'b0; // see R14
		end else begin
			case (sel)
				dosel_pkg::MS_0,
				dosel_pkg::MS_7: ok = !pn; // see R6 see R11 see R12 see R19
				dosel_pkg::MS_2: ok = (tgt != dosel_pkg::MODE_PANEL) && (cur != dosel_pkg::MODE_PANEL); // see R8
				dosel_pkg::MS_6: ok = 1'b1; // see R10
				default:         ok = 1'b0; // see R7
			endcase
		end
		// Only select 6 lets a switch happen with the motor turning.
		if (sel != dosel_pkg::MS_6 && !stopped) begin
			ok = 1'b0; // see R1
		end
		return ok;
	endfunction

	// ----------------------------------------------------------------
	// State and decode
	// ----------------------------------------------------------------
	localparam dosel_pkg::dosel_state_s ST_RST = '{
		startup_set: dosel_pkg::STARTUP_RST,
		startup_act: dosel_pkg::STARTUP_RST,
		modesel:     dosel_pkg::MODESEL_RST,
		coast:       dosel_pkg::COAST_RST,
		mode:        dosel_pkg::MODE_TERMINAL,
		refused:     1'b0,
		net_en:      1'b0,
		pu_prev:     1'b0,
		init:        1'b1,
		rdata:       16'h0000,
		net_ack:     1'b0,
		net_nak:     1'b0,
		resume:      1'b0,
		start_clear: 1'b0
	};

	dosel_pkg::dosel_state_s st_r;
	dosel_pkg::dosel_state_s st_nxt;
	dosel_pkg::dosel_mode_e  dec_mode;
	dosel_pkg::dosel_mode_e  req_tgt;
	logic [7:0]              dec_su;
	logic                    req_v;
	logic                    req_panel;
	logic                    pu_edge;
	logic                    stopped;
	logic                    forced;
	logic                    start_active;
	logic                    clear_case;

	// On the start-up cycle the pending setting is used, since it is being latched right then.
	assign dec_su       = st_r.init ? st_r.startup_set : st_r.startup_act;
	assign stopped      = !running_in && !forward_start_input_in && !reverse_start_input_in;
	assign forced       = (st_r.modesel == dosel_pkg::MS_7) && !mode_lock_input_in;
	assign pu_edge      = pu_net_switch_input_in != st_r.pu_prev;
	assign start_active = forward_start_input_in || reverse_start_input_in;
	assign clear_case   = start_active &&
	                      (st_r.startup_act == dosel_pkg::SU_1 || st_r.startup_act == dosel_pkg::SU_10);

	dosel_start_decode u_start (
		.startup_in (dec_su),
		.modesel_in (st_r.modesel),
		.lock_in    (mode_lock_input_in),
		.mode_out   (dec_mode)
	);

	// One request per cycle; the switch input beats the panel keys, which beat software.
	always_comb begin
		req_v     = 1'b0;
		req_panel = 1'b0;
		req_tgt   = dosel_pkg::MODE_TERMINAL;
		if (pu_edge) begin
			req_v     = 1'b1;
			req_panel = 1'b1;
			req_tgt   = pu_net_switch_input_in ? dosel_pkg::MODE_PANEL : dosel_pkg::MODE_NETWORK; // see R16
		end else if (panel_mode_req_in) begin
			req_v     = 1'b1;
			req_panel = 1'b1;
			req_tgt   = dosel_pkg::dosel_mode_e'(panel_mode_tgt_in);
		end else if (wr_in && addr_in == dosel_pkg::REG_MODE_REQ) begin
			req_v     = 1'b1;
			req_tgt   = dosel_pkg::dosel_mode_e'(wdata_in[1:0]);
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt             = st_r;
		st_nxt.pu_prev     = pu_net_switch_input_in;
		st_nxt.rdata       = 16'h0000;
		st_nxt.net_ack     = 1'b0;
		st_nxt.net_nak     = 1'b0;
		st_nxt.resume      = 1'b0;
		st_nxt.start_clear = 1'b0;

		// Register writes; the startup code only lands in the pending copy.
		if (wr_in) begin
			case (addr_in)
				dosel_pkg::REG_STARTUP: st_nxt.startup_set = wdata_in[7:0]; // see R4
				dosel_pkg::REG_MODESEL: st_nxt.modesel = wdata_in[3:0];
				dosel_pkg::REG_COAST:   st_nxt.coast = wdata_in;
				dosel_pkg::REG_STATUS:  st_nxt.refused = st_r.refused && !wdata_in[dosel_pkg::ST_REFUSED_BIT];
				default:                st_nxt.coast = st_r.coast;
			endcase
		end
		// The panel reaches the startup code whatever the current mode.
		if (panel_startup_wr_in) begin
			st_nxt.startup_set = panel_startup_data_in; // see R5
		end

		// Read data appear one cycle after the strobe; unmapped reads give zero.
		if (rd_in) begin
			case (addr_in)
				dosel_pkg::REG_STARTUP:  st_nxt.rdata = {8'h00, st_r.startup_set};
				dosel_pkg::REG_MODESEL:  st_nxt.rdata = {12'h000, st_r.modesel};
				dosel_pkg::REG_COAST:    st_nxt.rdata = st_r.coast;
				dosel_pkg::REG_MODE_REQ: st_nxt.rdata = {14'h0000, st_r.mode};
				dosel_pkg::REG_STATUS:   st_nxt.rdata = {st_r.startup_act, 4'h0, st_r.net_en,
				                                          st_r.refused, st_r.mode};
				default:                 st_nxt.rdata = 16'h0000;
			endcase
		end

		// Mode sequencing: start-up, power recovery, forced terminal, then requests.
		if (st_r.init) begin
			st_nxt.startup_act = st_r.startup_set; // see R4
			st_nxt.mode        = dec_mode; // see R2 see R12
			st_nxt.init        = 1'b0;
		end else if (power_restore_in) begin
			st_nxt.mode        = dec_mode; // see R2
			st_nxt.start_clear = clear_case; // see R18
			st_nxt.resume      = (st_r.coast != dosel_pkg::COAST_NONE) && !clear_case; // see R17
		end else if (forced) begin
			st_nxt.mode = dosel_pkg::MODE_TERMINAL; // see R11
		end else if (req_v) begin
			if (allow_switch(st_r.startup_act, st_r.modesel, st_r.mode, req_tgt, req_panel, stopped)) begin
				st_nxt.mode = req_tgt; // see R1
			end else begin
				st_nxt.refused = 1'b1; // Set beats a clear in the same cycle.
			end
		end
		if (drive_reset_in) begin
			st_nxt.init = 1'b1; // see R4
		end

		// Network parameter writes are acknowledged only while in network mode, refused otherwise.
		st_nxt.net_en  = st_nxt.mode == dosel_pkg::MODE_NETWORK;
		st_nxt.net_ack = net_write_req_in && st_r.net_en; // see R3
		st_nxt.net_nak = net_write_req_in && !st_r.net_en; // see R3
	end

	// ----------------------------------------------------------------
	// State register and outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata_out         = st_r.rdata;
	assign mode_out          = st_r.mode;
	assign net_write_en_out  = st_r.net_en;
	assign net_write_ack_out = st_r.net_ack;
	assign net_write_nak_out = st_r.net_nak;
	assign refused_out       = st_r.refused;
	assign resume_out        = st_r.resume;
	assign start_clear_out   = st_r.start_clear;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	logic quiet;
	assign quiet = !st_r.init && !power_restore_in;

	sequence s_dip_with_start;
		!st_r.init ##0 power_restore_in ##0 clear_case;
	endsequence

	sequence s_wide_run_swap;
		is_wide(st_r.startup_act) && st_r.modesel == dosel_pkg::MS_6 && running_in
		&& st_r.mode == dosel_pkg::MODE_NETWORK && pu_edge && pu_net_switch_input_in;
	endsequence

	a_refuse_running: assert property (quiet && req_v && !stopped && !forced // see R1
		&& st_r.modesel != dosel_pkg::MS_6 |=> $stable(st_r.mode))
		else $error("mode changed while the drive was not stopped");
	a_start_network: assert property (st_r.init && st_r.startup_set != dosel_pkg::SU_0 // see R2
		&& (st_r.modesel == dosel_pkg::MS_0 || st_r.modesel == dosel_pkg::MS_6)
		|=> mode_out == dosel_pkg::MODE_NETWORK)
		else $error("nonzero startup code did not start network mode");
	a_net_write_gate: assert property (net_write_req_in |=> // see R3
		(net_write_ack_out == $past(st_r.net_en)) && (net_write_nak_out != $past(st_r.net_en)))
		else $error("network write answer does not match the mode");
	a_startup_latch: assert property (!st_r.init |=> $stable(st_r.startup_act)) // see R4
		else $error("active startup code changed outside start-up");
	a_panel_startup: assert property (panel_startup_wr_in |=> // see R5
		st_r.startup_set == $past(panel_startup_data_in))
		else $error("panel write of startup code was lost");
	a_no_direct_hop: assert property (quiet && st_r.startup_act == dosel_pkg::SU_0 // see R6
		&& st_r.modesel == dosel_pkg::MS_0 && st_r.mode == dosel_pkg::MODE_PANEL
		|=> mode_out != dosel_pkg::MODE_NETWORK)
		else $error("direct panel to network switch");
	a_panel_fixed: assert property (quiet && st_r.modesel == dosel_pkg::MS_1 // see R7
		&& st_r.mode == dosel_pkg::MODE_PANEL |=> mode_out == dosel_pkg::MODE_PANEL)
		else $error("panel mode left under select 1");
	a_no_panel_sel2: assert property (quiet && st_r.modesel == dosel_pkg::MS_2 // see R8
		&& st_r.mode != dosel_pkg::MODE_PANEL |=> mode_out != dosel_pkg::MODE_PANEL)
		else $error("entered panel mode under select 2");
	a_combined_held: assert property (quiet && st_r.mode == dosel_pkg::MODE_COMBINED // see R9
		&& (st_r.modesel == dosel_pkg::MS_3 || st_r.modesel == dosel_pkg::MS_4)
		|=> mode_out == dosel_pkg::MODE_COMBINED)
		else $error("combined mode left under select 3 or 4");
	a_run_switch: assert property (quiet && !forced && st_r.modesel == dosel_pkg::MS_6 // see R10
		&& st_r.startup_act == dosel_pkg::SU_0 && pu_edge && st_r.mode == dosel_pkg::MODE_TERMINAL
		|=> mode_out == $past(req_tgt))
		else $error("switch refused under select 6");
	a_forced_term: assert property (quiet && forced |=> // see R11
		mode_out == dosel_pkg::MODE_TERMINAL [*1] ##0 net_write_en_out == 1'b0)
		else $error("terminal mode not forced with lock off");
	a_wide_no_term: assert property (quiet && is_wide(st_r.startup_act) // see R13
		&& st_r.modesel == dosel_pkg::MS_0 && st_r.mode != dosel_pkg::MODE_TERMINAL
		|=> mode_out != dosel_pkg::MODE_TERMINAL)
		else $error("terminal mode entered under startup 10 or 12");
	a_wide_net_held: assert property (quiet && is_wide(st_r.startup_act) // see R14
		&& st_r.modesel == dosel_pkg::MS_2 |=> $stable(st_r.mode))
		else $error("network mode left under startup 10 or 12 with select 2");
	a_wide_run_swap: assert property (quiet ##0 s_wide_run_swap // see R15
		|=> mode_out == dosel_pkg::MODE_PANEL ##1 net_write_en_out == 1'b0)
		else $error("panel switch refused while running");
	a_soft_wide: assert property (quiet && is_wide(st_r.startup_act) && req_v && !req_panel // see R16
		&& (st_r.modesel == dosel_pkg::MS_0 || st_r.modesel == dosel_pkg::MS_6) |=> $stable(st_r.mode))
		else $error("software switched panel and network mode");
	a_resume: assert property (!st_r.init && power_restore_in && !clear_case // see R17
		&& st_r.coast != dosel_pkg::COAST_NONE |=> resume_out ##1 !resume_out)
		else $error("no resume after power dip");
	a_start_clear: assert property (s_dip_with_start |=> start_clear_out && !resume_out) // see R18
		else $error("start command survived a power dip");
	a_wide_sel1: assert property (st_r.init && is_wide(st_r.startup_set) // see R19
		&& st_r.modesel == dosel_pkg::MS_1 |=> mode_out == dosel_pkg::MODE_PANEL)
		else $error("startup 10 or 12 with select 1 did not start in panel mode");

endmodule

// [bench/dosel_far_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Operator panel and network option card
// ----------------------------------------------------------------
module dosel_far_model (
	input  wire logic  clk_in,
	input  wire logic  net_write_ack_in,
	input  wire logic  net_write_nak_in,
	output logic       pu_net_switch_out,
	output logic       panel_mode_req_out,
	output logic [1:0] panel_mode_tgt_out,
	output logic       panel_startup_wr_out,
	output logic [7:0] panel_startup_data_out,
	output logic       net_write_req_out
);
	// Idle levels; released data are inverted so a stale value never looks valid.
	initial begin
		pu_net_switch_out = 1'b0;
		panel_mode_req_out = 1'b0;
		panel_mode_tgt_out = 2'h0;
		panel_startup_wr_out = 1'b0;
		panel_startup_data_out = 8'h00;
		net_write_req_out = 1'b0;
	end
	// Panel key request; the gap lets the panel act promptly or slowly.
	task automatic key(input logic [1:0] tgt, input int gap);
		repeat (gap) @(posedge clk_in);
		@(posedge clk_in);
		panel_mode_req_out <= 1'b1;
		panel_mode_tgt_out <= tgt;
		@(posedge clk_in);
		panel_mode_req_out <= 1'b0;
		panel_mode_tgt_out <= ~tgt;
	endtask
	// Switch input level: high asks for panel mode, low for network mode.
	task automatic flip(input logic lvl, input int gap);
		repeat (gap) @(posedge clk_in);
		@(posedge clk_in);
		pu_net_switch_out <= lvl;
		@(posedge clk_in);
	endtask
	// Panel write of the startup code, allowed whatever the mode.
	task automatic startup(input logic [7:0] v, input int gap);
		repeat (gap) @(posedge clk_in);
		@(posedge clk_in);
		panel_startup_wr_out <= 1'b1;
		panel_startup_data_out <= v;
		@(posedge clk_in);
		panel_startup_wr_out <= 1'b0;
		panel_startup_data_out <= ~v;
	endtask
	// Network parameter write; the reply stands only in the next cycle.
	task automatic net_wr(input int gap, output logic ack, output logic nak);
		repeat (gap) @(posedge clk_in);
		@(posedge clk_in);
		net_write_req_out <= 1'b1;
		@(posedge clk_in);
		net_write_req_out <= 1'b0;
		@(negedge clk_in);
		ack = net_write_ack_in;
		nak = net_write_nak_in;
	endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench of the mode selector
// ----------------------------------------------------------------
module tb;
	logic        clk_in, rst_in, wr_in, rd_in, drive_reset_in, power_restore_in, running_in;
	logic        fwd, rev, lock, pu_s, pk_req, ps_wr, nw_req, ack, nak, lk, byp, e, f, rn, pu_lvl;
	logic [1:0]  pk_tgt, mode_out, m, tg;
	logic [2:0]  addr_in;
	logic [7:0]  ps_data, su, act, v8;
	logic [3:0]  sel;
	logic [15:0] wdata_in, rdata_out, d, coast;
	logic        nwe, ack_o, nak_o, refused_out, resume_out, start_clear_out;
	int          mismatches, n_compared;
	localparam logic [7:0] SUS [5] = '{8'h00, 8'h01, 8'h02, 8'h0a, 8'h0c};
	localparam logic [3:0] SELS [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};

	dosel_mode_ctrl DUT (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .drive_reset_in(drive_reset_in), .power_restore_in(power_restore_in),
		.running_in(running_in), .forward_start_input_in(fwd), .reverse_start_input_in(rev),
		.mode_lock_input_in(lock), .pu_net_switch_input_in(pu_s), .panel_mode_req_in(pk_req),
		.panel_mode_tgt_in(pk_tgt), .panel_startup_wr_in(ps_wr), .panel_startup_data_in(ps_data),
		.net_write_req_in(nw_req), .rdata_out(rdata_out), .mode_out(mode_out), .net_write_en_out(nwe),
		.net_write_ack_out(ack_o), .net_write_nak_out(nak_o), .refused_out(refused_out),
		.resume_out(resume_out), .start_clear_out(start_clear_out));
	dosel_far_model FAR (.clk_in(clk_in), .net_write_ack_in(ack_o), .net_write_nak_in(nak_o),
		.pu_net_switch_out(pu_s), .panel_mode_req_out(pk_req), .panel_mode_tgt_out(pk_tgt),
		.panel_startup_wr_out(ps_wr), .panel_startup_data_out(ps_data), .net_write_req_out(nw_req));

	// ----------------------------------------------------------------
	// Expectations and bus tasks
	// ----------------------------------------------------------------
	function automatic logic [1:0] start_of(logic [7:0] s, logic [3:0] q, logic l);
		if (q == 4'h1) return 2'h1;
		if (q == 4'h3 || q == 4'h4) return 2'h3;
		if (q == 4'h7) return ((s == 8'h01 || s == 8'h02) && l) ? 2'h2 : 2'h0;
		return (s == 8'h00) ? 2'h0 : 2'h2;
	endfunction
	// Panel and network may only be swapped directly where the settings say so.
	function automatic logic ok(logic [7:0] s, logic [3:0] q, logic [1:0] c, logic [1:0] t, logic p, logic stp);
		logic pn = (c inside {2'h1, 2'h2}) && (t inside {2'h1, 2'h2});
		if (t == c || t == 2'h3 || q inside {4'h1, 4'h3, 4'h4}) return 1'b0;
		if (!stp && q != 4'h6) return 1'b0;
		if (s == 8'h0a || s == 8'h0c) begin
			if (q == 4'h2) return 1'b0;
			if (q == 4'h0 || q == 4'h6) return pn && p;
		end
		if (q == 4'h2) return t != 2'h1 && c != 2'h1;
		return q == 4'h6 || !pn;
	endfunction
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] v);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] v);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		v = rdata_out;
	endtask
	// Drive reset pulse, then the init cycle, then one settled cycle.
	task automatic reinit();
		@(posedge clk_in);
		drive_reset_in <= 1'b1;
		@(posedge clk_in);
		drive_reset_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ----------------------------------------------------------------
	// Free-running 50 MHz clock.
	always #10 clk_in = ~clk_in;
	// The tests need about 4000 cycles; a hang is cut off well beyond that.
	initial begin
		repeat (50000) @(posedge clk_in);
		mismatches++;
		results();
	end
	// Reset checks, then random settings and requests with corner cases.
	initial begin
		{clk_in, wr_in, rd_in, drive_reset_in, power_restore_in, running_in, fwd, rev, pu_lvl} = '0;
		{rst_in, lock, addr_in, wdata_in, act, mismatches, n_compared} = {1'b1, 92'h0};
		void'($urandom(87));
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rd(3'h0, d); chk("startup reset", 16'h0000, d);
		rd(3'h1, d); chk("select reset", 16'h0000, d);
		rd(3'h2, d); chk("coast reset", dosel_pkg::COAST_RST, d);
		wr(3'h5, 16'hffff); rd(3'h5, d); chk("unmapped", 16'h0000, d);
		@(negedge clk_in); chk("rdata idle", 16'h0000, rdata_out);
		$display("test reset done");
		repeat (60) begin
			su = SUS[$urandom % 5];
			sel = SELS[$urandom % 7];
			lk = ($urandom % 4) != 0;
			@(posedge clk_in);
			lock <= lk;
			wr(3'h0, 16'(su));
			wr(3'h1, 16'(sel));
			wr(3'h4, 16'h0004);
			rd(3'h4, d); chk("active before reset", 16'(act), d >> 8);
			reinit();
			act = su;
			m = mode_out;
			chk("start mode", 16'(start_of(su, sel, lk)), 16'(m));
			rd(3'h4, d); chk("status", {act, 4'h0, m == 2'h2, 1'b0, m}, d);
			repeat (6) begin
				if (sel == 4'h7 && !lk) break;
				{rn, f, e} = {($urandom % 4) == 0, ($urandom % 6) == 0, ($urandom % 6) == 0};
				@(posedge clk_in);
				running_in <= rn;
				fwd <= f;
				rev <= e;
				wr(3'h4, 16'h0004);
				@(negedge clk_in);
				m = mode_out;
				case ($urandom % 3)
					0: begin
						tg = 2'($urandom);
						byp = 1'b0;
						wr(3'h3, 16'(tg));
					end
					1: begin
						tg = 2'($urandom);
						byp = 1'b1;
						FAR.key(tg, $urandom % 3);
					end
					default: begin
						pu_lvl = ~pu_lvl;
						tg = pu_lvl ? 2'h1 : 2'h2;
						byp = 1'b1;
						FAR.flip(pu_lvl, $urandom % 3);
					end
				endcase
				@(negedge clk_in);
				e = ok(act, sel, m, tg, byp, !(rn | f | e));
				chk("mode after request", 16'(e ? tg : m), 16'(mode_out));
				chk("refused", 16'(!e), 16'(refused_out));
			end
			@(posedge clk_in);
			{running_in, rev} <= 2'b00;
			FAR.net_wr($urandom % 3, ack, nak);
			chk("net ack", 16'(mode_out == 2'h2), 16'(ack));
			chk("net nak", 16'(mode_out != 2'h2), 16'(nak));
			v8 = 8'($urandom);
			FAR.startup(v8, $urandom % 2);
			rd(3'h0, d); chk("panel startup", 16'(v8), d);
			rd(3'h4, d); chk("active kept", 16'(act), d >> 8);
			coast = ($urandom % 2) ? dosel_pkg::COAST_NONE : 16'($urandom);
			f = 1'($urandom % 2);
			wr(3'h2, coast);
			@(posedge clk_in);
			fwd <= f;
			power_restore_in <= 1'b1;
			@(posedge clk_in);
			power_restore_in <= 1'b0;
			@(negedge clk_in);
			e = (act == 8'h01 || act == 8'h0a) && f;
			chk("start clear", 16'(e), 16'(start_clear_out));
			chk("resume", 16'(!e && coast != dosel_pkg::COAST_NONE), 16'(resume_out));
			chk("restore mode", 16'(start_of(act, sel, lk)), 16'(mode_out));
			@(posedge clk_in);
			fwd <= 1'b0;
		end
		$display("test random settings done");
		wr(3'h0, 16'h0001);
		wr(3'h1, 16'h0007);
		@(posedge clk_in);
		lock <= 1'b1;
		reinit();
		chk("lock on start", 16'h0002, 16'(mode_out));
		@(posedge clk_in);
		lock <= 1'b0;
		repeat (2) @(posedge clk_in);
		@(negedge clk_in); chk("lock off forced", 16'h0000, 16'(mode_out));
		wr(3'h3, 16'h0002);
		@(negedge clk_in); chk("lock off held", 16'h0000, 16'(mode_out));
		$display("test lock done");
		results();
	end
endmodule
